/* File: vpa_params.svh */
// offsets, field positions and reset values for the phy ident and advert bank
`ifndef VPA_PARAMS_SVH
`define VPA_PARAMS_SVH

`define VPA_OFS_IDENT_HIGH 12'h1C8
`define VPA_OFS_IDENT_LOW 12'h1CC
`define VPA_OFS_ADVERT 12'h1D0
`define VPA_IDX_IDENT_HIGH 5'h02
`define VPA_IDX_IDENT_LOW 5'h03
`define VPA_IDX_ADVERT 5'h04
`define VPA_RST_IDENT_HIGH 16'h0000
`define VPA_RST_IDENT_LOW 16'h0000
`define VPA_ADV_WR_MASK 16'h0DFF
`define VPA_ADV_BIT_PAUSE 10
`define VPA_ADV_RST_BASE 16'h01E1

`endif

/* File: vpa_pkg.sv */
// types for the phy ident and advert bank
package vpa_pkg;
   typedef enum logic [1:0] {
      VPA_SEL_NONE,
      VPA_SEL_IDENT_HIGH,
      VPA_SEL_IDENT_LOW,
      VPA_SEL_ADVERT
   } vpa_sel_type;
endpackage

/* File: vpa_regs.sv */
// phy identifier and autoneg advertisement register bank
//
// Contract
// (RULE1) offsets 1C8h,1CCh,1D0h match indices 2,3,4
// (RULE2) host reads 32 bits, upper half zero
// (RULE3) ident high: writable 16 bits, reset zero
// (RULE4) ident low: oui, model, revision, reset zero
// (RULE5) eeprom loader overwrites whole advert register
// (RULE6) next page bit reads zero always
// (RULE7) remote fault, bits 14,12 read zero
// (RULE8) asymmetric pause writable, resets zero
// (RULE9) pause default is inverse of strap
// (RULE10) strap captured at reset release
// (RULE11) t4 ability bit reads zero always
// (RULE12) bits 8 to 5 writable, reset one
// (RULE13) selector writable, resets 00001b
// (RULE14) read-only bit writes ignored, read zero
`timescale 1ns/1ps
`include "vpa_params.svh"
`default_nettype none

module vpa_regs
   import vpa_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // strap pin, asynchronous
   input wire logic flow_ctrl_pin_strap,
   // host register map
   input wire logic host_rd,
   input wire logic host_wr,
   input wire logic [11:0] host_addr,
   input wire logic [31:0] host_wdata,
   output logic [31:0] host_rdata,
   // mii management side, 16 bit
   input wire logic mgmt_rd,
   input wire logic mgmt_wr,
   input wire logic [4:0] mgmt_reg,
   input wire logic [15:0] mgmt_wdata,
   output logic [15:0] mgmt_rdata,
   // eeprom loader
   input wire logic ee_load,
   input wire logic [15:0] ee_data,
   // decoded fields
   output logic [15:0] ident_high_out,
   output logic [15:0] ident_low_out,
   output logic [15:0] advert_out
);

   // ------------------------------------------------------------
   // strap capture
   // ------------------------------------------------------------
   logic strap_s1_reg;
   logic strap_s2_reg;
   logic strap_done_reg;
   logic strap_reg;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         strap_s1_reg <= 1'b0;
         strap_s2_reg <= 1'b0;
      end else begin
         strap_s1_reg <= flow_ctrl_pin_strap;
         strap_s2_reg <= strap_s1_reg;
      end
   end

   // caught once, on the first settled sample after release
   logic [1:0] rel_cnt_reg;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rel_cnt_reg <= 2'h0;
         strap_done_reg <= 1'b0;
         strap_reg <= 1'b0;
      end else if (!strap_done_reg) begin
         rel_cnt_reg <= rel_cnt_reg + 2'h1;
         if (rel_cnt_reg == 2'h2) begin
            strap_reg <= strap_s2_reg; // [RULE10]
            strap_done_reg <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   vpa_sel_type host_sel;
   vpa_sel_type mgmt_sel;

   always_comb begin
      case (host_addr) // [RULE1]
         `VPA_OFS_IDENT_HIGH: host_sel = VPA_SEL_IDENT_HIGH;
         `VPA_OFS_IDENT_LOW: host_sel = VPA_SEL_IDENT_LOW;
         `VPA_OFS_ADVERT: host_sel = VPA_SEL_ADVERT;
         default: host_sel = VPA_SEL_NONE;
      endcase
   end

   always_comb begin
      case (mgmt_reg) // [RULE1]
         `VPA_IDX_IDENT_HIGH: mgmt_sel = VPA_SEL_IDENT_HIGH;
         `VPA_IDX_IDENT_LOW: mgmt_sel = VPA_SEL_IDENT_LOW;
         `VPA_IDX_ADVERT: mgmt_sel = VPA_SEL_ADVERT;
         default: mgmt_sel = VPA_SEL_NONE;
      endcase
   end

   // host write wins over a management write in the same cycle
   logic wr_en;
   vpa_sel_type wr_sel;
   logic [15:0] wr_data;
   always_comb begin
      wr_en = 1'b0;
      wr_sel = VPA_SEL_NONE;
      wr_data = 16'h0000;
      if (host_wr) begin
         wr_en = 1'b1;
         wr_sel = host_sel;
         wr_data = host_wdata[15:0]; // [RULE2]
      end else if (mgmt_wr) begin
         wr_en = 1'b1;
         wr_sel = mgmt_sel;
         wr_data = mgmt_wdata;
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [15:0] ident_high_reg;
   logic [15:0] ident_low_reg;
   logic [15:0] advert_reg;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ident_high_reg <= `VPA_RST_IDENT_HIGH; // [RULE3]
      end else if (wr_en && wr_sel == VPA_SEL_IDENT_HIGH) begin
         ident_high_reg <= wr_data; // [RULE3]
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ident_low_reg <= `VPA_RST_IDENT_LOW; // [RULE4]
      end else if (wr_en && wr_sel == VPA_SEL_IDENT_LOW) begin
         ident_low_reg <= wr_data; // [RULE4]
      end
   end

   // pause default waits on the strap, so it is applied when the capture lands
   logic [15:0] adv_default;
   always_comb begin
      adv_default = `VPA_ADV_RST_BASE; // [RULE12] [RULE13] [RULE8]
      adv_default[`VPA_ADV_BIT_PAUSE] = ~strap_reg; // [RULE9]
   end

   logic strap_done_d_reg;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         strap_done_d_reg <= 1'b0;
      end else begin
         strap_done_d_reg <= strap_done_reg;
      end
   end
   logic strap_land;
   assign strap_land = strap_done_reg && !strap_done_d_reg;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         advert_reg <= `VPA_ADV_RST_BASE & ~(16'h0001 << `VPA_ADV_BIT_PAUSE);
      end else if (strap_land) begin
         advert_reg <= adv_default; // [RULE9]
      end else if (ee_load) begin
         advert_reg <= ee_data & `VPA_ADV_WR_MASK; // [RULE5] [RULE6] [RULE7] [RULE11]
      end else if (wr_en && wr_sel == VPA_SEL_ADVERT) begin
         advert_reg <= wr_data & `VPA_ADV_WR_MASK; // [RULE14] [RULE13]
      end
   end

   // ------------------------------------------------------------
   // read paths
   // ------------------------------------------------------------
   function automatic logic [15:0] vpa_pick(input vpa_sel_type s, input logic [15:0] h,
                                            input logic [15:0] l, input logic [15:0] a);
      case (s)
         VPA_SEL_IDENT_HIGH: vpa_pick = h;
         VPA_SEL_IDENT_LOW: vpa_pick = l;
         VPA_SEL_ADVERT: vpa_pick = a;
         default: vpa_pick = 16'h0000;
      endcase
   endfunction

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         host_rdata <= 32'h00000000;
      end else if (host_rd) begin
         host_rdata <= {16'h0000, // [RULE2]
            vpa_pick(host_sel, ident_high_reg, ident_low_reg, advert_reg)};
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         mgmt_rdata <= 16'h0000;
      end else if (mgmt_rd) begin
         mgmt_rdata <= vpa_pick(mgmt_sel, ident_high_reg, ident_low_reg, advert_reg);
      end
   end

   assign ident_high_out = ident_high_reg;
   assign ident_low_out = ident_low_reg;
   assign advert_out = advert_reg;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_fixed_zero;
      @(posedge sys_clk) disable iff (!nrst)
      advert_reg[15:12] == 4'h0 && advert_reg[9] == 1'b0;
   endproperty
   a_fixed_zero: assert property (p_fixed_zero) else $error("fixed advert bits set"); // [RULE6]

   property p_host_upper_zero;
      @(posedge sys_clk) disable iff (!nrst)
      host_rdata[31:16] == 16'h0000;
   endproperty
   a_host_upper_zero: assert property (p_host_upper_zero) else $error("upper half set"); // [RULE2]

   property p_pause_default;
      @(posedge sys_clk) disable iff (!nrst)
      strap_land |=> advert_reg[`VPA_ADV_BIT_PAUSE] == ~$past(strap_reg)
         && advert_reg[8:0] == 9'h1E1 && advert_reg[11] == 1'b0;
   endproperty
   a_pause_default: assert property (p_pause_default) else $error("bad advert default"); // [RULE9]

   property p_ee_load;
      @(posedge sys_clk) disable iff (!nrst)
      (ee_load && !strap_land) |=> advert_reg == ($past(ee_data) & 16'h0DFF);
   endproperty
   a_ee_load: assert property (p_ee_load) else $error("eeprom load lost"); // [RULE5]

   property p_ident_high_wr;
      @(posedge sys_clk) disable iff (!nrst)
      (host_wr && host_addr == 12'h1C8) |=> ident_high_reg == $past(host_wdata[15:0]);
   endproperty
   a_ident_high_wr: assert property (p_ident_high_wr) else $error("ident high write lost"); // [RULE3]

   property p_ident_low_mgmt;
      @(posedge sys_clk) disable iff (!nrst)
      (mgmt_wr && !host_wr && mgmt_reg == 5'h03) |=> ident_low_reg == $past(mgmt_wdata);
   endproperty
   a_ident_low_mgmt: assert property (p_ident_low_mgmt) else $error("ident low write lost"); // [RULE4]

   property p_mgmt_read;
      @(posedge sys_clk) disable iff (!nrst)
      (mgmt_rd && mgmt_reg == 5'h04) |=> mgmt_rdata == $past(advert_reg);
   endproperty
   a_mgmt_read: assert property (p_mgmt_read) else $error("mgmt advert read wrong"); // [RULE1]

   property p_unmapped_read;
      @(posedge sys_clk) disable iff (!nrst)
      (host_rd && host_sel == VPA_SEL_NONE) |=> host_rdata == 32'h00000000;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read nonzero"); // [RULE14]

   property p_strap_once;
      @(posedge sys_clk) disable iff (!nrst)
      strap_done_reg |=> strap_done_reg && $stable(strap_reg);
   endproperty
   a_strap_once: assert property (p_strap_once) else $error("strap changed after capture"); // [RULE10]

   property p_advert_wr;
      @(posedge sys_clk) disable iff (!nrst)
      (host_wr && host_addr == 12'h1D0 && !strap_land && !ee_load)
         |=> advert_reg == ($past(host_wdata[15:0]) & 16'h0DFF);
   endproperty
   a_advert_wr: assert property (p_advert_wr) else $error("advert write not masked"); // [RULE14]

   property p_mgmt_advert_wr;
      @(posedge sys_clk) disable iff (!nrst)
      (mgmt_wr && !host_wr && mgmt_reg == 5'h04 && !strap_land && !ee_load)
         |=> advert_reg == ($past(mgmt_wdata) & 16'h0DFF);
   endproperty
   a_mgmt_advert_wr: assert property (p_mgmt_advert_wr) else $error("mgmt advert bad"); // [RULE14]

   // both ports writing one register: the host word must be the one kept
   property p_host_wins;
      @(posedge sys_clk) disable iff (!nrst)
      (host_wr && mgmt_wr && host_addr == 12'h1CC && mgmt_reg == 5'h03)
         |=> ident_low_reg == $past(host_wdata[15:0]);
   endproperty
   a_host_wins: assert property (p_host_wins) else $error("host write lost"); // [RULE4]

   property p_host_read;
      @(posedge sys_clk) disable iff (!nrst)
      (host_rd && host_addr == 12'h1C8)
         |=> host_rdata == {16'h0000, $past(ident_high_reg)};
   endproperty
   a_host_read: assert property (p_host_read) else $error("host ident read wrong"); // [RULE1]

   property p_mgmt_unmapped;
      @(posedge sys_clk) disable iff (!nrst)
      (mgmt_rd && mgmt_sel == VPA_SEL_NONE) |=> mgmt_rdata == 16'h0000;
   endproperty
   a_mgmt_unmapped: assert property (p_mgmt_unmapped) else $error("mgmt unmapped nonzero"); // [RULE14]

endmodule

`default_nettype wire

/* File: vpa_host_model.sv */
// host cpu and mii management master model for the phy ident and advert bank
`timescale 1ns/1ps
`default_nettype none

module vpa_host_model (
   // clock
   input wire logic sys_clk,
   // host register map
   output logic host_rd,
   output logic host_wr,
   output logic [11:0] host_addr,
   output logic [31:0] host_wdata,
   input wire logic [31:0] host_rdata,
   // mii management side
   output logic mgmt_rd,
   output logic mgmt_wr,
   output logic [4:0] mgmt_reg,
   output logic [15:0] mgmt_wdata,
   input wire logic [15:0] mgmt_rdata,
   // eeprom loader
   output logic ee_load,
   output logic [15:0] ee_data
);
   initial begin
      {host_rd, host_wr, mgmt_rd, mgmt_wr, ee_load} = 5'h00;
      host_addr = 12'h000;
      host_wdata = 32'h00000000;
      mgmt_reg = 5'h00;
      mgmt_wdata = 16'h0000;
      ee_data = 16'h0000;
   end
   // -----------------------------------------
   // accesses: entered and left just after an edge
   // -----------------------------------------
   task automatic hw(input logic [11:0] a, input logic [31:0] d);
      host_addr = a;
      host_wdata = d;
      host_wr = 1'b1;
      @(posedge sys_clk);
      #1 host_wr = 1'b0;
      host_wdata = ~d;
   endtask
   // rdata is registered on the taking edge, so it is read right after it
   task automatic hr(input logic [11:0] a, output logic [31:0] d);
      host_addr = a;
      host_rd = 1'b1;
      @(posedge sys_clk);
      #1 host_rd = 1'b0;
      d = host_rdata;
   endtask
   // 16 bit management view of the same registers
   task automatic mw(input logic [4:0] r, input logic [15:0] d);
      mgmt_reg = r;
      mgmt_wdata = d;
      mgmt_wr = 1'b1;
      @(posedge sys_clk);
      #1 mgmt_wr = 1'b0;
      mgmt_wdata = ~d;
   endtask
   task automatic mr(input logic [4:0] r, output logic [15:0] d);
      mgmt_reg = r;
      mgmt_rd = 1'b1;
      @(posedge sys_clk);
      #1 mgmt_rd = 1'b0;
      d = mgmt_rdata;
   endtask
   // loader rewrites the whole advert word
   task automatic ee(input logic [15:0] d);
      ee_data = d;
      ee_load = 1'b1;
      @(posedge sys_clk);
      #1 ee_load = 1'b0;
      ee_data = ~d;
   endtask
endmodule

`default_nettype wire

/* File: virtual_phy_id_and_an_advert_tb.sv */
// self-checking bench for the phy ident and advert bank
`timescale 1ns/1ps
`include "vpa_params.svh"
`default_nettype none

`define CHK(a, e) begin checks++; if ((a) !== (e)) begin bad_count++; \
   $display("wrong value at %0t: got %h want %h", $time, (a), (e)); end end

module virtual_phy_id_and_an_advert_tb;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic strap = 1'b0;
   logic host_rd, host_wr, mgmt_rd, mgmt_wr, ee_load;
   logic [11:0] host_addr;
   logic [31:0] host_wdata, host_rdata, w;
   logic [4:0] mgmt_reg;
   logic [15:0] mgmt_wdata, mgmt_rdata, ee_data, ih, il, adv, h;
   int bad_count = 0;
   int checks = 0;
   int cyc = 0;

   always #4 sys_clk = ~sys_clk;

   vpa_regs vpa_regs_i (.sys_clk(sys_clk), .nrst(nrst), .flow_ctrl_pin_strap(strap),
      .host_rd(host_rd), .host_wr(host_wr), .host_addr(host_addr),
      .host_wdata(host_wdata), .host_rdata(host_rdata), .mgmt_rd(mgmt_rd),
      .mgmt_wr(mgmt_wr), .mgmt_reg(mgmt_reg), .mgmt_wdata(mgmt_wdata),
      .mgmt_rdata(mgmt_rdata), .ee_load(ee_load), .ee_data(ee_data),
      .ident_high_out(ih), .ident_low_out(il), .advert_out(adv));

   vpa_host_model vpa_host_model_i (.sys_clk(sys_clk), .host_rd(host_rd), .host_wr(host_wr),
      .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
      .mgmt_rd(mgmt_rd), .mgmt_wr(mgmt_wr), .mgmt_reg(mgmt_reg), .mgmt_wdata(mgmt_wdata),
      .mgmt_rdata(mgmt_rdata), .ee_load(ee_load), .ee_data(ee_data));

   task automatic complete_run();
      if (bad_count == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // strap is latched a few edges after release, so requests wait 6 edges
   task automatic do_reset(input logic s);
      #1 nrst = 1'b0;
      strap = s;
      repeat (16) @(posedge sys_clk);
      #1 nrst = 1'b1;
      repeat (6) @(posedge sys_clk);
      #1;
   endtask

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 2000) begin
         bad_count++;
         complete_run();
      end
   end

   initial begin
      do_reset(1'b0);
      `CHK(adv, 16'h05E1)
      `CHK(ih, 16'h0000)
      `CHK(il, 16'h0000)
      vpa_host_model_i.hr(12'h1D0, w);
      `CHK(w, 32'h000005E1)
      vpa_host_model_i.hw(12'h1D0, 32'hFFFFFFE1);
      vpa_host_model_i.hr(12'h1D0, w);
      `CHK(w, 32'h00000DE1)
      vpa_host_model_i.hw(12'h1D0, 32'h00000001);
      vpa_host_model_i.mr(5'h04, h);
      `CHK(h, 16'h0001)
      vpa_host_model_i.hw(12'h1C8, 32'hFFFF1234);
      vpa_host_model_i.mr(5'h02, h);
      `CHK(h, 16'h1234)
      vpa_host_model_i.mw(5'h03, 16'hA5C3);
      vpa_host_model_i.hr(12'h1CC, w);
      `CHK(w, 32'h0000A5C3)
      vpa_host_model_i.mw(5'h04, 16'hFC61);
      vpa_host_model_i.hr(12'h1D0, w);
      `CHK(w, 32'h00000C61)
      vpa_host_model_i.ee(16'hF0E1);
      `CHK(adv, 16'h00E1)
      vpa_host_model_i.hr(12'h1D4, w);
      `CHK(w, 32'h00000000)
      vpa_host_model_i.hw(12'h1D4, 32'h0000FFFF);
      vpa_host_model_i.hr(12'h1C8, w);
      `CHK(w, 32'h00001234)
      // both ports write one register in the same cycle; host wins
      fork
         vpa_host_model_i.hw(12'h1CC, 32'h00003C5A);
         vpa_host_model_i.mw(5'h03, 16'h1111);
      join
      `CHK(il, 16'h3C5A)
      vpa_host_model_i.mr(5'h05, h);
      `CHK(h, 16'h0000)
      // strap moves after capture; the default must not follow it
      do_reset(1'b1);
      #1 strap = 1'b0;
      repeat (8) @(posedge sys_clk);
      #1 `CHK(adv, 16'h01E1)
      `CHK(ih, 16'h0000)
      `CHK(il, 16'h0000)
      complete_run();
   end
endmodule

`default_nettype wire
